// ### rtl/ecu_capture.sv
// Two-channel event capture timer with APB register slave
//
// Local design decisions: the APB slave port and the register offsets.
`default_nettype none
module ecu_capture
   import ecu_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Capture pins and interrupt
   input wire logic [1:0] i_capture_input_pin,
   output logic o_capture_irq
);
   ecu_state_t q; // Registered state
   ecu_state_t d; // Next state
   logic setup; // APB setup phase seen
   logic wr; // Write setup
   logic rd; // Read setup
   logic [1:0] rise; // Synchronised rising edge per channel
   logic [1:0] fall; // Synchronised falling edge per channel
   logic [1:0] ev_a; // Start event per channel
   logic [1:0] ev_b; // End event per channel
   logic [1:0] done; // Completion per channel
   logic [1:0] rearm; // Restart write per channel
   logic [31:0] rdata; // Read mux output
   logic hit; // Address is mapped

   // Bus decode: answer one cycle after setup, in the access phase
   assign setup = i_psel && !i_penable;
   assign wr = setup && i_pwrite;
   assign rd = setup && !i_pwrite;

   // Read multiplexer
   always_comb
   begin
      rdata = 32'h0;
      hit = 1'b1;
      case (i_paddr)
         ECU_OFS_TIMER: rdata = {16'h0, q.timer};
         ECU_OFS_CONFIG: rdata = {24'h0, q.config_r};
         ECU_OFS_RESTART: rdata = {30'h0, q.restart};
         ECU_OFS_FLAGS: rdata = {30'h0, q.flags};
         ECU_OFS_DIVIDER: rdata = {16'h0, q.divider};
         ECU_OFS_MASK: rdata = {30'h0, q.mask};
         default:
         begin
            hit = 1'b0;
            // Stamp block: six words from the stamp base
            for (int c = 0; c < 2; c++)
            begin
               for (int k = 0; k < 3; k++)
               begin
                  if (i_paddr == ECU_OFS_STAMP0 + 8'((c * 3 + k) * 4))
                  begin
                     rdata = {16'h0, q.stamp[c][k]};
                     hit = 1'b1;
                  end
               end
            end
         end
      endcase
   end

   // Next-state logic
   always_comb
   begin
      d = q;
      // Default: answer lines drop after each access phase
      d.pready = setup;
      d.pslverr = setup && !hit;
      d.prdata = rd ? rdata : 32'h0;

      // Divided clock tick advances the shared timer
      if (q.div_cnt + 16'h1 >= q.divider)
      begin
         d.div_cnt = 16'h0;
         d.timer = q.timer + 16'h1;
      end
      else
      begin
         d.div_cnt = q.div_cnt + 16'h1;
      end

      // Per-channel synchroniser, edges and sequence
      for (int c = 0; c < 2; c++)
      begin
         d.sync[c].s1 = i_capture_input_pin[c];
         d.sync[c].s2 = q.sync[c].s1;
         d.sync[c].s3 = q.sync[c].s2;
         // Level changes only when second and third stages agree
         if (q.sync[c].s2 == q.sync[c].s3)
         begin
            d.sync[c].level = q.sync[c].s3;
         end
         rise[c] = (q.sync[c].s2 == q.sync[c].s3) && q.sync[c].s3 && !q.sync[c].level;
         fall[c] = (q.sync[c].s2 == q.sync[c].s3) && !q.sync[c].s3 && q.sync[c].level;
         // Edge polarity selection
         ev_a[c] = q.config_r[c*ECU_CFG_STRIDE+ECU_CFG_START_RISE] ? rise[c] : fall[c];
         ev_b[c] = q.config_r[c*ECU_CFG_STRIDE+ECU_CFG_END_RISE] ? rise[c] : fall[c];
         done[c] = 1'b0;
         rearm[c] = wr && (i_paddr == ECU_OFS_RESTART) && i_pwdata[c];
         case (q.seq[c])
            ECU_IDLE:
            begin
               // Disarmed: events ignored until restart written
               if (rearm[c] || q.restart[c])
               begin
                  d.seq[c] = ECU_WAIT_A;
               end
            end
            ECU_WAIT_A:
            begin
               // Only a start event opens a sequence
               if (ev_a[c])
               begin
                  d.stamp[c][0] = q.timer;
                  d.seq[c] = ECU_WAIT_B;
               end
            end
            ECU_WAIT_B:
            begin
               if (ev_b[c])
               begin
                  d.stamp[c][1] = q.timer;
                  if (q.config_r[c*ECU_CFG_STRIDE+ECU_CFG_END_DONE])
                  begin
                     done[c] = 1'b1;
                  end
                  else
                  begin
                     d.seq[c] = ECU_WAIT_AA;
                  end
               end
            end
            ECU_WAIT_AA:
            begin
               if (ev_a[c])
               begin
                  d.stamp[c][2] = q.timer;
                  done[c] = 1'b1;
               end
            end
            default: d.seq[c] = ECU_IDLE;
         endcase
         if (done[c])
         begin
            if (q.config_r[c*ECU_CFG_STRIDE+ECU_CFG_FREE_RUN])
            begin
               d.seq[c] = ECU_WAIT_A;
            end
            else
            begin
               d.seq[c] = ECU_IDLE;
               d.restart[c] = 1'b0;
            end
         end
      end

      // Register writes
      if (wr)
      begin
         case (i_paddr)
            ECU_OFS_CONFIG: d.config_r = i_pwdata[7:0];
            ECU_OFS_DIVIDER:
            begin
               d.divider = i_pwdata[15:0];
               d.div_cnt = 16'h0;
            end
            ECU_OFS_MASK: d.mask = i_pwdata[1:0];
            default: ;
         endcase
      end
      // Restart bits: a write sets, single-shot completion clears, set wins
      for (int c = 0; c < 2; c++)
      begin
         if (rearm[c])
         begin
            d.restart[c] = 1'b1;
         end
         else if (q.config_r[c*ECU_CFG_STRIDE+ECU_CFG_FREE_RUN] && q.seq[c] != ECU_IDLE)
         begin
            d.restart[c] = 1'b1;
         end
      end

      // Status: read clears, a completion in the same cycle still sets
      if (rd && i_paddr == ECU_OFS_FLAGS)
      begin
         d.flags = 2'h0;
      end
      d.flags = d.flags | done;
      d.irq = |(d.flags & d.mask);
   end

   // State register
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         q <= '0;
         q.divider <= ECU_DIVIDER_RST;
         q.config_r <= ECU_CONFIG_RST;
         q.restart <= ECU_RESTART_RST;
         q.mask <= ECU_MASK_RST;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_prdata = q.prdata;
   assign o_pready = q.pready;
   assign o_pslverr = q.pslverr;
   assign o_capture_irq = q.irq;

   // Assertions
   chk_irq_follows_flags: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(q.flags[0]) && q.mask[0] |-> o_capture_irq)
      else $error("irq not raised on channel 0 completion");
   chk_flag_read_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
      rd && i_paddr == ECU_OFS_FLAGS && done == 2'h0 |=> q.flags == 2'h0)
      else $error("status not cleared by read");
   chk_done_sets_flag: assert property (@(posedge i_mclk) disable iff (i_reset)
      done[1] |=> q.flags[1])
      else $error("channel 1 completion not flagged");
   chk_single_shot_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
      done[0] && !q.config_r[ECU_CFG_FREE_RUN] |=> q.seq[0] == ECU_IDLE)
      else $error("single shot channel 0 still armed");
   chk_free_run_rearm: assert property (@(posedge i_mclk) disable iff (i_reset)
      done[1] && q.config_r[ECU_CFG_STRIDE+ECU_CFG_FREE_RUN] |=> q.seq[1] == ECU_WAIT_A)
      else $error("free running channel 1 not rearmed");
   chk_restart_arms: assert property (@(posedge i_mclk) disable iff (i_reset)
      rearm[0] |=> q.restart[0] ##1 q.seq[0] != ECU_IDLE || done[0])
      else $error("restart did not arm channel 0");
   chk_start_stamp: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[0] == ECU_WAIT_A && ev_a[0] |=> q.stamp[0][0] == $past(q.timer) && q.seq[0] == ECU_WAIT_B)
      else $error("start stamp wrong");
   chk_restart_cleared: assert property (@(posedge i_mclk) disable iff (i_reset)
      done[1] && !q.config_r[ECU_CFG_STRIDE+ECU_CFG_FREE_RUN] && !rearm[1] |=> !q.restart[1])
      else $error("restart bit not cleared");
   chk_timer_steps: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.divider == 16'h1 && !wr |=> q.timer == $past(q.timer) + 16'h1)
      else $error("timer did not step");

   // Further checks on timer, bus answer and channel sequencing

   // Between divided ticks the timer keeps its count
   chk_timer_held: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.div_cnt + 16'h1 < q.divider |=> q.timer == $past(q.timer))
      else $error("timer moved between ticks");

   // Timer read returns the count seen at the setup cycle
   chk_timer_read: assert property (@(posedge i_mclk) disable iff (i_reset)
      rd && i_paddr == ECU_OFS_TIMER |=> o_prdata == {16'h0, $past(q.timer)})
      else $error("timer read value wrong");

   // Every setup cycle is answered in the following cycle
   chk_ready_after_setup: assert property (@(posedge i_mclk) disable iff (i_reset)
      setup |=> o_pready)
      else $error("no ready after setup");

   // Ready stands for exactly one cycle
   chk_ready_one_cycle: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_pready |=> !o_pready)
      else $error("ready held too long");

   // Error response only comes with ready
   chk_slverr_with_ready: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_pslverr |-> o_pready)
      else $error("error without ready");

   // Read data is zero outside the access phase
   chk_rdata_idle_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
      !o_pready |-> o_prdata == 32'h0)
      else $error("read data not zero while idle");

   // A configuration write lands in the register
   chk_config_write: assert property (@(posedge i_mclk) disable iff (i_reset)
      wr && i_paddr == ECU_OFS_CONFIG |=> q.config_r == $past(i_pwdata[7:0]))
      else $error("configuration write lost");

   // Channel 0 rising start opens the sequence when selected
   chk_rise_start0: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[0] == ECU_WAIT_A && rise[0] && q.config_r[ECU_CFG_START_RISE]
      |=> q.seq[0] == ECU_WAIT_B)
      else $error("channel 0 rising start missed");

   // Channel 1 falling start opens the sequence when selected
   chk_fall_start1: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[1] == ECU_WAIT_A && fall[1] && !q.config_r[ECU_CFG_STRIDE+ECU_CFG_START_RISE]
      |=> q.seq[1] == ECU_WAIT_B)
      else $error("channel 1 falling start missed");

   // Channel 1 rising end stamps the timer when selected
   chk_end_stamp1: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[1] == ECU_WAIT_B && rise[1] && q.config_r[ECU_CFG_STRIDE+ECU_CFG_END_RISE]
      |=> q.stamp[1][1] == $past(q.timer))
      else $error("channel 1 end stamp wrong");

   // No end stamp is taken before a start event
   chk_no_early_end: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[0] == ECU_WAIT_A |=> q.stamp[0][1] == $past(q.stamp[0][1]))
      else $error("end stamp before start");

   // Second start stamps the timer
   chk_second_stamp0: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[0] == ECU_WAIT_AA && ev_a[0] |=> q.stamp[0][2] == $past(q.timer))
      else $error("second start stamp wrong");

   // Channel 0 completes at its end event when selected
   chk_end_done0: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[0] == ECU_WAIT_B && ev_b[0] && q.config_r[ECU_CFG_END_DONE] |=> q.flags[0])
      else $error("channel 0 end completion missed");

   // Channel 1 waits for a second start when end completion is off
   chk_wait_second1: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[1] == ECU_WAIT_B && ev_b[1] && !q.config_r[ECU_CFG_STRIDE+ECU_CFG_END_DONE]
      |=> q.seq[1] == ECU_WAIT_AA)
      else $error("channel 1 did not wait for second start");

   // Interrupt only while an enabled flag is set
   chk_irq_needs_flag: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_capture_irq |-> (q.flags & q.mask) != 2'h0)
      else $error("interrupt without enabled flag");

   // Channel 0 completion sets its flag
   chk_done_flag0: assert property (@(posedge i_mclk) disable iff (i_reset)
      done[0] |=> q.flags[0])
      else $error("channel 0 completion not flagged");

   // Free-running channel 0 re-arms after completion
   chk_free_rearm0: assert property (@(posedge i_mclk) disable iff (i_reset)
      done[0] && q.config_r[ECU_CFG_FREE_RUN] |=> q.seq[0] == ECU_WAIT_A)
      else $error("free running channel 0 not rearmed");

   // A disarmed channel ignores its pin and keeps its stamps
   chk_idle_ignores1: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.seq[1] == ECU_IDLE && !q.restart[1] && !rearm[1]
      |=> q.seq[1] == ECU_IDLE && q.stamp[1] == $past(q.stamp[1]))
      else $error("disarmed channel 1 reacted");

   // Restart write sets the channel 1 bit
   chk_restart_write1: assert property (@(posedge i_mclk) disable iff (i_reset)
      rearm[1] |=> q.restart[1])
      else $error("restart write lost on channel 1");

   // Free-running channel keeps its restart bit while armed
   chk_free_keeps_bit: assert property (@(posedge i_mclk) disable iff (i_reset)
      q.config_r[ECU_CFG_FREE_RUN] && q.seq[0] != ECU_IDLE |=> q.restart[0])
      else $error("free running restart bit dropped");

   // Single-shot completion clears the channel 0 restart bit
   chk_restart_cleared0: assert property (@(posedge i_mclk) disable iff (i_reset)
      done[0] && !q.config_r[ECU_CFG_FREE_RUN] && !rearm[0] |=> !q.restart[0])
      else $error("channel 0 restart bit not cleared");
endmodule // ecu_capture
`default_nettype wire

// ### rtl/ecu_pkg.sv
// Package: register map, field positions and types of the event capture unit
`default_nettype none
package ecu_pkg;
   // Register byte offsets on APB
   localparam logic [7:0] ECU_OFS_TIMER = 8'h00;
   localparam logic [7:0] ECU_OFS_CONFIG = 8'h04;
   localparam logic [7:0] ECU_OFS_RESTART = 8'h08;
   localparam logic [7:0] ECU_OFS_FLAGS = 8'h0C;
   localparam logic [7:0] ECU_OFS_DIVIDER = 8'h10;
   localparam logic [7:0] ECU_OFS_MASK = 8'h14;
   localparam logic [7:0] ECU_OFS_STAMP0 = 8'h20;
   localparam logic [7:0] ECU_STAMP_STRIDE = 8'h04;
   // Configuration field positions, per-channel stride of 4 bits
   localparam int ECU_CFG_START_RISE = 0;
   localparam int ECU_CFG_END_RISE = 1;
   localparam int ECU_CFG_END_DONE = 2;
   localparam int ECU_CFG_FREE_RUN = 3;
   localparam int ECU_CFG_STRIDE = 4;
   // Reset values
   localparam logic [7:0] ECU_CONFIG_RST = 8'h00;
   localparam logic [15:0] ECU_DIVIDER_RST = 16'h0001;
   localparam logic [1:0] ECU_RESTART_RST = 2'h0;
   localparam logic [1:0] ECU_MASK_RST = 2'h3;
   // Capture sequence of one channel
   typedef enum logic [1:0] {ECU_IDLE, ECU_WAIT_A, ECU_WAIT_B, ECU_WAIT_AA} ecu_seq_t;
   // Pin synchroniser of one channel
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } ecu_sync_t;
   // Whole module state
   typedef struct packed {
      logic [15:0] divider;
      logic [15:0] div_cnt;
      logic [15:0] timer;
      logic [7:0] config_r;
      logic [1:0] restart;
      logic [1:0] flags;
      logic [1:0] mask;
      ecu_sync_t [1:0] sync;
      ecu_seq_t [1:0] seq;
      logic [1:0][2:0][15:0] stamp;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } ecu_state_t;
endpackage : ecu_pkg
`default_nettype wire

// ### verification/ecu_pin_model.sv
// Model of the external signal sources on the two capture pins
`default_nettype none
module ecu_pin_model
(
   // Clock used to pace the edges
   input wire logic i_mclk,
   // Levels seen by the capture unit
   output logic [1:0] o_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pins rest low until a scenario moves them
   initial o_pin = 2'b00;
   // Move one pin right after an edge, then hold it for gap cycles
   task automatic drive(input int ch, input logic lvl, input int gap);
      o_pin[ch] <= lvl;
      repeat (gap) @(posedge i_mclk);
   endtask
endmodule // ecu_pin_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the two-channel event capture timer
`default_nettype none
module tb_top
   import ecu_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // Bus, clock and pin signals
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [1:0] pin;
   int n_fail = 0;
   int check_count = 0;
   // 20 MHz clock
   initial forever #25 mclk = ~mclk;
   ecu_capture u_dut (.i_mclk(mclk), .i_reset(reset), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_capture_input_pin(pin), .o_capture_irq(irq));
   ecu_pin_model u_pins (.i_mclk(mclk), .o_pin(pin));
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; entered and left just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge mclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask
   // Read and compare a register
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      rd(a, r);
      chk(nm, exp, r);
   endtask
   // Read stamp k of a channel
   task automatic rs(input int ch, input int k, output logic [31:0] r);
      rd(ECU_OFS_STAMP0 + 8'(3 * ch + k) * ECU_STAMP_STRIDE, r);
   endtask
   // Let registered updates land, then look at the interrupt
   task automatic chk_irq(input logic exp, input string nm);
      repeat (2) @(posedge mclk);
      chk(nm, {31'h0, exp}, {31'h0, irq});
   endtask
   // Reset values, read-write access and an unmapped place
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rdc(ECU_OFS_CONFIG, {24'h0, ECU_CONFIG_RST}, "config_rst");
      rdc(ECU_OFS_RESTART, {30'h0, ECU_RESTART_RST}, "restart_rst");
      rdc(ECU_OFS_FLAGS, 32'h0, "flags_rst");
      rdc(ECU_OFS_DIVIDER, {16'h0, ECU_DIVIDER_RST}, "divider_rst");
      rdc(ECU_OFS_MASK, {30'h0, ECU_MASK_RST}, "mask_rst");
      wr(ECU_OFS_CONFIG, 32'hA5);
      rdc(ECU_OFS_CONFIG, 32'hA5, "config_rw");
      apb(1'b0, 8'h3C, 32'h0, r, e);
      chk("unmapped_err", 32'h1, {31'h0, e});
      chk("unmapped_data", 32'h0, r);
      $display("test reset done");
   endtask
   // Divided timer rate over two reads eight cycles apart
   task automatic t_timer();
      logic [31:0] t0, t1;
      wr(ECU_OFS_DIVIDER, 32'h4);
      rd(ECU_OFS_TIMER, t0);
      repeat (5) @(posedge mclk);
      rd(ECU_OFS_TIMER, t1);
      chk("timer_delta", 32'h2, t1 - t0);
      wr(ECU_OFS_DIVIDER, 32'h1);
      $display("test timer done");
   endtask
   // Channel 0 single shot: rising start, falling end, done at second start
   task automatic t_single();
      logic [31:0] a, b, aa, a2;
      u_pins.drive(0, 1'b1, 8);
      wr(ECU_OFS_CONFIG, 32'h01);
      wr(ECU_OFS_RESTART, 32'h1);
      u_pins.drive(0, 1'b0, 10);
      u_pins.drive(0, 1'b1, 12);
      u_pins.drive(0, 1'b0, 17);
      chk_irq(1'b0, "irq_after_end");
      u_pins.drive(0, 1'b1, 10);
      chk_irq(1'b1, "irq_done");
      rs(0, 0, a);
      rs(0, 1, b);
      rs(0, 2, aa);
      chk("ch0_end_gap", 32'd12, b - a);
      chk("ch0_start_gap", 32'd19, aa - b);
      rdc(ECU_OFS_FLAGS, 32'h1, "flags_ch0");
      rdc(ECU_OFS_RESTART, 32'h0, "restart_ch0");
      rdc(ECU_OFS_FLAGS, 32'h0, "flags_cleared");
      chk_irq(1'b0, "irq_cleared");
      u_pins.drive(0, 1'b0, 8);
      u_pins.drive(0, 1'b1, 10);
      rdc(ECU_OFS_FLAGS, 32'h0, "flags_ignored");
      rs(0, 0, a2);
      chk("ch0_stamp_held", a, a2);
      $display("test single done");
   endtask
   // Channel 1 free running: falling start, rising end, done at end
   task automatic t_free();
      logic [31:0] a, b;
      wr(ECU_OFS_CONFIG, 32'hE0);
      wr(ECU_OFS_MASK, 32'h1);
      wr(ECU_OFS_RESTART, 32'h2);
      u_pins.drive(1, 1'b1, 10);
      u_pins.drive(1, 1'b0, 14);
      u_pins.drive(1, 1'b1, 10);
      chk_irq(1'b0, "irq_masked");
      rs(1, 0, a);
      rs(1, 1, b);
      chk("ch1_end_gap", 32'd14, b - a);
      rdc(ECU_OFS_RESTART, 32'h2, "restart_kept");
      wr(ECU_OFS_MASK, 32'h3);
      chk_irq(1'b1, "irq_unmasked");
      rdc(ECU_OFS_FLAGS, 32'h2, "flags_ch1");
      u_pins.drive(1, 1'b0, 9);
      u_pins.drive(1, 1'b1, 10);
      rs(1, 0, a);
      rs(1, 1, b);
      chk("rerun_gap", 32'd9, b - a);
      rdc(ECU_OFS_FLAGS, 32'h2, "flags_rerun");
      $display("test free done");
   endtask
   // Verdict and end of run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_timer();
      t_single();
      t_free();
      complete_run();
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
